// File: inc/ncap_pkg.sv
/*
  Constants, commands and state types for the host-side NAND port
  controller. Assumes a 250 MHz system clock.
*/
package ncap_pkg;

  // ---------------------------------------------------------------
  // timing
  // ---------------------------------------------------------------
  localparam int CLK_NS     = 4;
  localparam int STROBE_NS  = 20;
  localparam int STROBE_CYC = (STROBE_NS + CLK_NS - 1) / CLK_NS;
  localparam int WB_NS      = 100;
  localparam int WB_CYC     = (WB_NS + CLK_NS - 1) / CLK_NS;
  localparam int CNT_W      = 8;

  // ---------------------------------------------------------------
  // command codes
  // ---------------------------------------------------------------
  localparam logic [7:0] C_READ     = 8'h00;
  localparam logic [7:0] C_READ_CF  = 8'h30;
  localparam logic [7:0] C_PROG     = 8'h80;
  localparam logic [7:0] C_PROG_CF  = 8'h10;
  localparam logic [7:0] C_CB1      = 8'h85;
  localparam logic [7:0] C_DUMMY_CF = 8'h11;
  localparam logic [7:0] C_CB2      = 8'h81;
  localparam logic [7:0] C_ERASE    = 8'h60;
  localparam logic [7:0] C_ERASE_CF = 8'hd0;
  localparam logic [7:0] C_STATUS   = 8'h70;
  localparam logic [7:0] C_RESET    = 8'hff;
  localparam logic [7:0] C_IDENT    = 8'h90;
  localparam logic [7:0] C_EDC      = 8'h7b;

  // ---------------------------------------------------------------
  // user operations
  // ---------------------------------------------------------------
  typedef enum logic [3:0] {
    OP_PAGE_READ = 4'h0,
    OP_PROGRAM   = 4'h1,
    OP_ERASE     = 4'h2,
    OP_STATUS    = 4'h3,
    OP_RESET     = 4'h4,
    OP_IDENT     = 4'h5,
    OP_EDC       = 4'h6,
    OP_COPY_DUAL = 4'h7,
    OP_ERASE_DUAL = 4'h8
  } ncap_op_e;

  typedef enum logic [2:0] {
    ST_IDLE  = 3'h0,
    ST_CMD1  = 3'h1,
    ST_ADDR  = 3'h3,
    ST_WDATA = 3'h2,
    ST_CMD2  = 3'h6,
    ST_BUSYW = 3'h7,
    ST_RDATA = 3'h5,
    ST_FIN   = 3'h4
  } ncap_st_e;

  // one stage of a command sequence
  typedef struct packed {
    logic [7:0] cmd1;
    logic       has_addr;
    logic [2:0] a_first;
    logic       has_wdat;
    logic       has_cmd2;
    logic [7:0] cmd2;
    logic       wait_busy;
    logic       has_rdat;
    logic       more;
    logic       modify;
  } ncap_desc_s;

endpackage

// File: hdl/ncap_host.sv
/*
  Host controller for an asynchronous NAND command/address/data port.
  Drives the strobes and the shared bus from one user request port.
  Assumes pin inputs synchronous to clk and an external bus resolver
  that turns io_o/io_oe into the shared wire.
*/
`timescale 1ns/1ps
module ncap_host #(
  parameter bit WIDE  = 1'b0,
  parameter int LEN_W = 12
) (
  input  wire logic             clk,
  input  wire logic             rstn,
  input  wire logic             en,
  input  wire logic             req_valid,
  input  wire logic [3:0]       req_op,
  input  wire logic [29:0]      req_addr,
  input  wire logic [29:0]      req_addr2,
  input  wire logic [LEN_W-1:0] req_len,
  output logic                  req_ready,
  output logic                  done,
  input  wire logic [15:0]      wr_data,
  input  wire logic             wr_valid,
  output logic                  wr_ready,
  output logic [15:0]           rd_data,
  output logic                  rd_valid,
  input  wire logic             rd_ready,
  input  wire logic             supply_ok,
  output logic                  nand_ce_n,
  output logic                  nand_cle,
  output logic                  nand_ale,
  output logic                  nand_we_n,
  output logic                  read_strobe_n,
  output logic                  nand_wp_n,
  output logic [15:0]           nand_io_o,
  output logic                  nand_io_oe,
  input  wire logic [15:0]      nand_io_i,
  input  wire logic             nand_rb_n
);

  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  typedef struct packed {
    ncap_pkg::ncap_st_e       st;
    logic [1:0]               ph;
    logic [ncap_pkg::CNT_W-1:0] cnt;
    logic [2:0]               idx;
    logic [LEN_W-1:0]         left;
    logic                     stage;
    logic [3:0]               op;
    logic [29:0]              addr;
    logic [29:0]              addr2;
    logic                     ce_n;
    logic                     cle;
    logic                     ale;
    logic                     we_n;
    logic                     re_n;
    logic                     wp_n;
    logic [15:0]              io;
    logic                     oe;
    logic [15:0]              b0;
    logic [15:0]              b1;
    logic [1:0]               bn;
    logic                     rv;
    logic                     wr_rdy;
    logic                     rdy;
    logic                     done;
  } ncap_state_s;

  ncap_state_s s_q;
  ncap_state_s s_d;
  logic        rst_m;
  logic        rst_n;
  ncap_pkg::ncap_desc_s dsc;

  localparam logic [ncap_pkg::CNT_W-1:0] STB =
    ncap_pkg::CNT_W'(ncap_pkg::STROBE_CYC - 1);
  localparam logic [ncap_pkg::CNT_W-1:0] WBC =
    ncap_pkg::CNT_W'(ncap_pkg::WB_CYC - 1);

  // ---------------------------------------------------------------
  // reset release
  // ---------------------------------------------------------------
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      rst_m <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rst_m <= 1'b1;
      rst_n <= rst_m;
    end
  end

  // ---------------------------------------------------------------
  // sequence table
  // ---------------------------------------------------------------
  function automatic ncap_pkg::ncap_desc_s desc(input logic [3:0] op,
                                                input logic stage);
    ncap_pkg::ncap_desc_s d;
    d = '0;
    d.a_first = 3'h0;
    unique case (op)
      ncap_pkg::OP_PAGE_READ: begin
        d = '{ncap_pkg::C_READ, 1'b1, 3'h0, 1'b0, 1'b1,
              ncap_pkg::C_READ_CF, 1'b1, 1'b1, 1'b0, 1'b0};
      end
      ncap_pkg::OP_PROGRAM: begin
        d = '{ncap_pkg::C_PROG, 1'b1, 3'h0, 1'b1, 1'b1,
              ncap_pkg::C_PROG_CF, 1'b1, 1'b0, 1'b0, 1'b1};
      end
      ncap_pkg::OP_ERASE: begin
        d = '{ncap_pkg::C_ERASE, 1'b1, 3'h2, 1'b0, 1'b1,
              ncap_pkg::C_ERASE_CF, 1'b1, 1'b0, 1'b0, 1'b1};
      end
      ncap_pkg::OP_STATUS: begin
        d = '{ncap_pkg::C_STATUS, 1'b0, 3'h0, 1'b0, 1'b0,
              8'h00, 1'b0, 1'b1, 1'b0, 1'b0};
      end
      ncap_pkg::OP_RESET: begin
        d = '{ncap_pkg::C_RESET, 1'b0, 3'h0, 1'b0, 1'b0,
              8'h00, 1'b1, 1'b0, 1'b0, 1'b0};
      end
      ncap_pkg::OP_IDENT: begin
        d = '{ncap_pkg::C_IDENT, 1'b1, 3'h4, 1'b0, 1'b0,
              8'h00, 1'b0, 1'b1, 1'b0, 1'b0};
      end
      ncap_pkg::OP_EDC: begin
        d = '{ncap_pkg::C_EDC, 1'b0, 3'h0, 1'b0, 1'b0,
              8'h00, 1'b0, 1'b1, 1'b0, 1'b0};
      end
      ncap_pkg::OP_COPY_DUAL: begin
        d = '{stage ? ncap_pkg::C_CB2 : ncap_pkg::C_CB1, 1'b1, 3'h0,
              1'b0, 1'b1,
              stage ? ncap_pkg::C_PROG_CF : ncap_pkg::C_DUMMY_CF,
              1'b1, 1'b0, !stage, 1'b1};
      end
      ncap_pkg::OP_ERASE_DUAL: begin
        d = '{ncap_pkg::C_ERASE, 1'b1, 3'h2, 1'b0, stage,
              ncap_pkg::C_ERASE_CF, stage, 1'b0, !stage, 1'b1};
      end
      default: d = '0;
    endcase
    return d;
  endfunction

  // address byte of one cycle; unused positions stay low
  function automatic logic [7:0] abyte(input logic [29:0] a,
                                       input logic [2:0] i);
    logic [7:0] b;
    b = 8'h00;
    if (!WIDE) begin
      unique case (i)
        3'h0:    b = a[7:0];
        3'h1:    b = {4'h0, a[11:8]};
        3'h2:    b = a[19:12];
        3'h3:    b = a[27:20];
        default: b = {6'h00, a[29:28]};
      endcase
    end else begin
      unique case (i)
        3'h0:    b = a[7:0];
        3'h1:    b = {5'h00, a[10:8]};
        3'h2:    b = a[18:11];
        3'h3:    b = a[26:19];
        default: b = {6'h00, a[28:27]};
      endcase
    end
    return b;
  endfunction

  // ---------------------------------------------------------------
  // next state
  // ---------------------------------------------------------------
  always_comb begin
    logic pop;
    logic push;
    logic [1:0] room;
    logic [15:0] cap;
    ncap_pkg::ncap_desc_s d_req;
    ncap_pkg::ncap_desc_s d_nxt;
    pop  = 1'b0;
    push = 1'b0;
    room = 2'h0;
    cap  = 16'h0000;
    d_req = desc(req_op, 1'b0);
    d_nxt = desc(s_q.op, 1'b1);
    s_d  = s_q;
    dsc  = desc(s_q.op, s_q.stage);
    s_d.done   = 1'b0;
    s_d.wr_rdy = 1'b0;
    pop = s_q.rv && rd_ready;
    room = s_q.bn - {1'b0, pop};
    unique case (s_q.st)
      ncap_pkg::ST_IDLE: begin
        s_d.ce_n = 1'b1;
        s_d.wp_n = 1'b0;
        // a busy device only takes reset or status
        if (req_valid && supply_ok && (nand_rb_n ||
            req_op == ncap_pkg::OP_STATUS ||
            req_op == ncap_pkg::OP_RESET)) begin
          s_d.op    = req_op;
          s_d.addr  = req_addr;
          s_d.addr2 = req_addr2;
          s_d.left  = req_len;
          s_d.stage = 1'b0;
          s_d.rdy   = 1'b0;
          s_d.st    = ncap_pkg::ST_CMD1;
          s_d.ph    = 2'h0;
          s_d.cnt   = STB;
          s_d.ce_n  = 1'b0;
          s_d.cle   = 1'b1;
          s_d.io    = {8'h00, d_req.cmd1};
          s_d.oe    = 1'b1;
          // lock stays low unless a modify sequence runs
          s_d.wp_n  = d_req.modify;
        end
      end
      ncap_pkg::ST_CMD1, ncap_pkg::ST_ADDR, ncap_pkg::ST_CMD2,
      ncap_pkg::ST_WDATA: begin
        if (s_q.ph == 2'h2) begin
          // wait for a data word from the user
          if (wr_valid) begin
            s_d.io     = WIDE ? wr_data : {8'h00, wr_data[7:0]};
            s_d.wr_rdy = 1'b1;
            s_d.ph     = 2'h0;
            s_d.cnt    = STB;
          end
        end else if (s_q.cnt != '0) begin
          s_d.cnt  = s_q.cnt - 1'b1;
          s_d.we_n = (s_q.ph != 2'h0);
        end else if (s_q.ph == 2'h0) begin
          s_d.we_n = 1'b1;
          s_d.ph   = 2'h1;
          s_d.cnt  = STB;
        end else begin
          s_d.ph  = 2'h0;
          s_d.cnt = STB;
          s_d.cle = 1'b0;
          s_d.ale = 1'b0;
          s_d.oe  = 1'b1;
          if (s_q.st == ncap_pkg::ST_CMD1 && dsc.has_addr) begin
            s_d.st  = ncap_pkg::ST_ADDR;
            s_d.idx = dsc.a_first;
            s_d.ale = 1'b1;
            s_d.io  = {8'h00, abyte(s_q.addr, dsc.a_first)};
          end else if (s_q.st == ncap_pkg::ST_ADDR && s_q.idx != 3'h4) begin
            s_d.idx = s_q.idx + 3'h1;
            s_d.ale = 1'b1;
            s_d.io  = {8'h00, abyte(s_q.addr, s_q.idx + 3'h1)};
          end else if (s_q.st != ncap_pkg::ST_WDATA &&
                       s_q.st != ncap_pkg::ST_CMD2 &&
                       dsc.has_wdat && s_q.left != '0) begin
            s_d.st = ncap_pkg::ST_WDATA;
            s_d.ph = 2'h2;
          end else if (s_q.st == ncap_pkg::ST_WDATA &&
                       s_q.left != {{(LEN_W-1){1'b0}}, 1'b1}) begin
            s_d.left = s_q.left - 1'b1;
            s_d.ph   = 2'h2;
          end else if (s_q.st != ncap_pkg::ST_CMD2 && dsc.has_cmd2) begin
            s_d.st  = ncap_pkg::ST_CMD2;
            s_d.cle = 1'b1;
            s_d.io  = {8'h00, dsc.cmd2};
          end else if (dsc.wait_busy) begin
            s_d.st  = ncap_pkg::ST_BUSYW;
            s_d.oe  = 1'b0;
            s_d.cnt = WBC;
          end else if (dsc.has_rdat) begin
            s_d.st = ncap_pkg::ST_RDATA;
            s_d.oe = 1'b0;
            s_d.ph = 2'h2;
          end else begin
            s_d.st = ncap_pkg::ST_FIN;
            s_d.oe = 1'b0;
          end
        end
      end
      ncap_pkg::ST_BUSYW: begin
        if (s_q.cnt != '0) begin
          s_d.cnt = s_q.cnt - 1'b1;
        end else if (nand_rb_n) begin
          s_d.cnt = STB;
          s_d.ph  = 2'h0;
          if (dsc.has_rdat) begin
            s_d.st = ncap_pkg::ST_RDATA;
            s_d.ph = 2'h2;
          end else begin
            s_d.st = ncap_pkg::ST_FIN;
          end
        end
      end
      ncap_pkg::ST_RDATA: begin
        // a full buffer holds the strobe high, so nothing is lost
        if (s_q.ph == 2'h2) begin
          if (room != 2'h2) begin
            s_d.ph   = 2'h0;
            s_d.cnt  = STB;
            s_d.re_n = 1'b0;
          end
        end else if (s_q.cnt != '0) begin
          s_d.cnt = s_q.cnt - 1'b1;
        end else if (s_q.ph == 2'h0) begin
          push     = 1'b1;
          cap      = WIDE ? nand_io_i : {8'h00, nand_io_i[7:0]};
          s_d.re_n = 1'b1;
          s_d.ph   = 2'h1;
          s_d.cnt  = STB;
        end else if (s_q.left > {{(LEN_W-1){1'b0}}, 1'b1}) begin
          s_d.left = s_q.left - 1'b1;
          s_d.ph   = 2'h2;
        end else begin
          s_d.st = ncap_pkg::ST_FIN;
        end
      end
      ncap_pkg::ST_FIN: begin
        if (dsc.more) begin
          s_d.stage = 1'b1;
          s_d.addr  = s_q.addr2;
          s_d.st    = ncap_pkg::ST_CMD1;
          s_d.ph    = 2'h0;
          s_d.cnt   = STB;
          s_d.cle   = 1'b1;
          s_d.oe    = 1'b1;
          s_d.io    = {8'h00, d_nxt.cmd1};
        end else begin
          s_d.st   = ncap_pkg::ST_IDLE;
          s_d.done = 1'b1;
          s_d.rdy  = 1'b1;
          s_d.ce_n = 1'b1;
          s_d.wp_n = 1'b0;
        end
      end
      default: s_d.st = ncap_pkg::ST_IDLE;
    endcase
    // two-entry read buffer
    if (pop) begin
      s_d.b0 = s_q.b1;
    end
    if (push) begin
      if (room == 2'h0) begin
        s_d.b0 = cap;
      end else begin
        s_d.b1 = cap;
      end
    end
    s_d.bn = room + {1'b0, push};
    s_d.rv = (s_d.bn != 2'h0);
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s_q      <= '0;
      s_q.st   <= ncap_pkg::ST_IDLE;
      s_q.ce_n <= 1'b1;
      s_q.we_n <= 1'b1;
      s_q.re_n <= 1'b1;
      s_q.rdy  <= 1'b1;
    end else if (en) begin
      s_q <= s_d;
    end
  end

  assign req_ready     = s_q.rdy;
  assign done          = s_q.done;
  assign wr_ready      = s_q.wr_rdy;
  assign rd_data       = s_q.b0;
  assign rd_valid      = s_q.rv;
  assign nand_ce_n     = s_q.ce_n;
  assign nand_cle      = s_q.cle;
  assign nand_ale      = s_q.ale;
  assign nand_we_n     = s_q.we_n;
  assign read_strobe_n = s_q.re_n;
  assign nand_wp_n     = s_q.wp_n;
  assign nand_io_o     = s_q.io;
  assign nand_io_oe    = s_q.oe;

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  a_cmd_low_lines: assert property (@(posedge clk) disable iff (!rst_n)
    nand_cle && !nand_we_n |-> !nand_ale && nand_io_o[15:8] == 8'h00)
    else $error("command not on low lines");
  a_addr_low_lines: assert property (@(posedge clk) disable iff (!rst_n)
    nand_ale && !nand_we_n |-> nand_io_o[15:8] == 8'h00 && !nand_cle)
    else $error("address upper lines not low");
  a_addr_last_pad: assert property (@(posedge clk) disable iff (!rst_n)
    nand_ale && !nand_we_n && s_q.idx == 3'h4 |-> nand_io_o[7:2] == 6'h00)
    else $error("fifth address cycle pad not low");
  a_read_strobe: assert property (@(posedge clk) disable iff (!rst_n)
    !read_strobe_n |-> nand_we_n && !nand_cle && !nand_ale && !nand_ce_n)
    else $error("read strobe with wrong pins");
  a_busy_cmds: assert property (@(posedge clk) disable iff (!rst_n)
    s_q.st == ncap_pkg::ST_IDLE && s_d.st == ncap_pkg::ST_CMD1 && en &&
    !nand_rb_n |-> req_op == ncap_pkg::OP_STATUS ||
    req_op == ncap_pkg::OP_RESET)
    else $error("command issued while busy");
  a_supply_lock: assert property (@(posedge clk) disable iff (!rst_n)
    s_q.st == ncap_pkg::ST_IDLE && !supply_ok |=> s_q.st == ncap_pkg::ST_IDLE)
    else $error("request taken under low supply");
  a_data_lock: assert property (@(posedge clk) disable iff (!rst_n)
    s_q.st == ncap_pkg::ST_WDATA && !nand_we_n |-> nand_wp_n &&
    read_strobe_n && !nand_cle && !nand_ale)
    else $error("data strobe with wrong pins");
  a_we_width: assert property (@(posedge clk) disable iff (!rst_n || !en)
    // the first count cycle only sets up the pins, so the low phase is
    // one cycle shorter than the counter load plus one
    $fell(nand_we_n) |-> !nand_we_n [*4] ##1 nand_we_n)
    else $error("write strobe width wrong");
  a_buf_stall: assert property (@(posedge clk) disable iff (!rst_n)
    s_q.bn == 2'h2 && !rd_ready |=> !$fell(read_strobe_n))
    else $error("read strobe while buffer full");
  a_lock_modify: assert property (@(posedge clk) disable iff (!rst_n)
    nand_cle && !nand_we_n && (nand_io_o[7:0] == ncap_pkg::C_PROG_CF ||
    nand_io_o[7:0] == ncap_pkg::C_ERASE_CF) |-> nand_wp_n)
    else $error("confirm issued with lock low");

endmodule

// File: test/ncap_nand_model.sv
/*
  Behavioural NAND device on the far side of the host port: logs
  commands, address bytes and data words, answers read strobes and
  pulls busy low after confirms and reset.
  Assumes the bench resolves the shared bus and the open-drain busy.
*/
`timescale 1ns/1ps
module ncap_nand_model #(
  parameter int         BUSY_CYC = 40,
  parameter logic [7:0] STAT_V   = 8'he0,
  parameter logic [7:0] EDC_V    = 8'h5a,
  parameter logic [7:0] ID_V     = 8'hc3  // arbitrary value
) (
  input  wire logic        clk,
  input  wire logic        ce_n,
  input  wire logic        cle,
  input  wire logic        ale,
  input  wire logic        we_n,
  input  wire logic        re_n,
  input  wire logic        wp_n,
  input  wire logic [15:0] io,
  input  wire logic        hold_busy,
  output logic      [15:0] dev_io,
  output logic             rb_n
);
  // ---------------------------------------------------------------
  // logs and state, read by the bench
  // ---------------------------------------------------------------
  logic [7:0]  cmd_log[$];
  logic [15:0] addr_log[$];
  logic [15:0] data_log[$];
  logic [7:0]  last_cmd  = 8'hff;
  logic [15:0] next_word = 16'h0000;
  logic [15:0] drv       = 16'h0000;
  int          busy_cnt  = 0;
  int          n_viol    = 0;
  int          n_re      = 0;

  assign rb_n   = !(busy_cnt > 0 || hold_busy);
  assign dev_io = drv;

  always @(posedge clk) if (busy_cnt > 0) busy_cnt <= busy_cnt - 1;

  // ---------------------------------------------------------------
  // write strobe latch
  // ---------------------------------------------------------------
  always @(posedge we_n) if (!ce_n) begin
    if (cle && !ale) begin
      if (!rb_n && io[7:0] != 8'hff && io[7:0] != 8'h70) n_viol++;
      if (!wp_n && io[7:0] inside {8'h10, 8'hd0}) n_viol++;
      cmd_log.push_back(io[7:0]);
      last_cmd  = io[7:0];
      next_word = 16'h0000;
      if (io[7:0] inside {8'h30, 8'h10, 8'hd0, 8'h11,
                          8'hff}) begin
        busy_cnt = BUSY_CYC;
      end
    end else if (ale && !cle) begin
      addr_log.push_back(io);
    end else if (!cle && !ale) begin
      if (!re_n || !wp_n) n_viol++;
      data_log.push_back(io);
    end else begin
      n_viol++;
    end
  end

  // ---------------------------------------------------------------
  // read strobe output
  // ---------------------------------------------------------------
  always @(negedge re_n) if (!ce_n && !cle && !ale && we_n) begin
    n_re++;
    case (last_cmd)
      8'h70:   drv = {8'h00, STAT_V};
      8'h7b:   drv = {8'h00, EDC_V};
      8'h90:   drv = {8'h00, ID_V};
      default: begin
        drv       = next_word;
        next_word = next_word + 16'h0111;
      end
    endcase
  end

  // bus no longer held after the strobe: show garbage, not the old word
  always @(posedge re_n) begin
    #4;
    drv = ~drv;
  end
endmodule

// File: test/tb_nand_command_address_port.sv
/*
  Self-checking bench for the host NAND port in byte-wide mode, with a
  word-wide copy in lockstep whose far-side pins are judged as well.
  Assumes the device model beside it and no other bus party.
*/
`timescale 1ns/1ps
`define CHK(g, e) \
  begin \
    total_checks++; \
    if ((g) !== (e)) begin \
      n_fail++; \
      $display("BAD t=%0t got=%h exp=%h", $time, (g), (e)); \
    end \
  end
module tb_nand_command_address_port;
  // ---------------------------------------------------------------
  // signals
  // ---------------------------------------------------------------
  localparam logic [29:0] A1 = 30'h2abc_d5e7;
  localparam logic [29:0] A2 = 30'h1357_9bdf;
  logic        clk = 1'b0, rstn = 1'b0, req_valid = 1'b0;
  logic [3:0]  req_op = 4'h0;
  logic [29:0] req_addr = 30'h0, req_addr2 = 30'h0;
  logic [11:0] req_len = 12'h000;
  logic [15:0] wr_data = 16'h00a5, io_o, dev_io, rd_data;
  logic        wr_valid = 1'b0, rd_ready = 1'b1, supply_ok = 1'b1, en = 1'b1;
  logic        hold_busy = 1'b0, req_ready, done, wr_ready, rd_valid;
  logic        ce_n, cle, ale, we_n, re_n, wp_n, io_oe, rb_n;
  logic [15:0] rx[$];
  int          n_fail = 0, total_checks = 0;
  wire  [15:0] io_i = io_oe ? io_o : dev_io;
  logic        w_ce_n, w_cle, w_ale, w_we_n, w_re_n, w_wp_n, w_oe, w_rb_n;
  logic [15:0] w_io_o, w_dev_io;
  wire  [15:0] w_io_i = w_oe ? w_io_o : w_dev_io;

  ncap_host #(.WIDE(1'b0), .LEN_W(12)) u_ncap_host (
    .clk(clk), .rstn(rstn), .en(en), .req_valid(req_valid),
    .req_op(req_op), .req_addr(req_addr), .req_addr2(req_addr2),
    .req_len(req_len), .req_ready(req_ready), .done(done),
    .wr_data(wr_data), .wr_valid(wr_valid), .wr_ready(wr_ready),
    .rd_data(rd_data), .rd_valid(rd_valid), .rd_ready(rd_ready),
    .supply_ok(supply_ok), .nand_ce_n(ce_n), .nand_cle(cle),
    .nand_ale(ale), .nand_we_n(we_n), .read_strobe_n(re_n),
    .nand_wp_n(wp_n), .nand_io_o(io_o), .nand_io_oe(io_oe),
    .nand_io_i(io_i), .nand_rb_n(rb_n));
  ncap_nand_model u_ncap_nand_model (
    .clk(clk), .ce_n(ce_n), .cle(cle), .ale(ale), .we_n(we_n),
    .re_n(re_n), .wp_n(wp_n), .io(io_i), .hold_busy(hold_busy),
    .dev_io(dev_io), .rb_n(rb_n));
  // same requests as above; word width changes data, never timing
  ncap_host #(.WIDE(1'b1), .LEN_W(12)) u_ncap_host_w (
    .clk(clk), .rstn(rstn), .en(en), .req_valid(req_valid),
    .req_op(req_op), .req_addr(req_addr), .req_addr2(req_addr2),
    .req_len(req_len), .req_ready(), .done(),
    .wr_data(wr_data), .wr_valid(wr_valid), .wr_ready(),
    .rd_data(), .rd_valid(), .rd_ready(rd_ready),
    .supply_ok(supply_ok), .nand_ce_n(w_ce_n), .nand_cle(w_cle),
    .nand_ale(w_ale), .nand_we_n(w_we_n), .read_strobe_n(w_re_n),
    .nand_wp_n(w_wp_n), .nand_io_o(w_io_o), .nand_io_oe(w_oe),
    .nand_io_i(w_io_i), .nand_rb_n(w_rb_n));
  ncap_nand_model u_ncap_nand_model_w (
    .clk(clk), .ce_n(w_ce_n), .cle(w_cle), .ale(w_ale), .we_n(w_we_n),
    .re_n(w_re_n), .wp_n(w_wp_n), .io(w_io_i), .hold_busy(hold_busy),
    .dev_io(w_dev_io), .rb_n(w_rb_n));

  initial begin
    forever #2 clk = ~clk;
  end
  always @(posedge clk)
    if (rd_valid === 1'b1 && rd_ready) rx.push_back(rd_data);
  always @(posedge clk) if (wr_ready === 1'b1) wr_data <= wr_data + 16'h0001;

  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  task automatic report_and_stop();
    if (n_fail == 0 && total_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  function automatic logic [15:0] ab(input logic [29:0] a, input int c);
    case (c)
      0:       return {8'h00, a[7:0]};
      1:       return {12'h000, a[11:8]};
      2:       return {8'h00, a[19:12]};
      3:       return {8'h00, a[27:20]};
      default: return {14'h0000, a[29:28]};
    endcase
  endfunction

  function automatic logic [15:0] ab16(input logic [29:0] a, input int c);
    case (c)
      0:       return {8'h00, a[7:0]};
      1:       return {13'h0000, a[10:8]};
      2:       return {8'h00, a[18:11]};
      3:       return {8'h00, a[26:19]};
      default: return {14'h0000, a[28:27]};
    endcase
  endfunction

  task automatic run_op(input logic [3:0] op, input logic [29:0] a,
                        input logic [29:0] a2, input logic [11:0] len);
    int i;
    u_ncap_nand_model.cmd_log.delete();
    u_ncap_nand_model.addr_log.delete();
    u_ncap_nand_model.data_log.delete();
    u_ncap_nand_model_w.addr_log.delete();
    u_ncap_nand_model_w.data_log.delete();
    u_ncap_nand_model.n_re = 0;
    rx.delete();
    @(posedge clk);
    req_op    <= op;
    req_addr  <= a;
    req_addr2 <= a2;
    req_len   <= len;
    req_valid <= 1'b1;
    for (i = 0; i < 5000 && done !== 1'b1; i++) begin
      @(posedge clk);
      if (req_ready === 1'b0) req_valid <= 1'b0;
    end
    if (i == 5000) begin
      n_fail++;
      report_and_stop();
    end
    repeat (4) @(posedge clk);
  endtask

  task automatic try_refused(input logic [3:0] op);
    u_ncap_nand_model.cmd_log.delete();
    @(posedge clk);
    req_op    <= op;
    req_valid <= 1'b1;
    repeat (60) @(posedge clk);
    `CHK(req_ready, 1'b1)
    `CHK(u_ncap_nand_model.cmd_log.size(), 0)
    req_valid <= 1'b0;
  endtask

  task automatic chk_cmds(input logic [31:0] exp, input int n);
    `CHK(u_ncap_nand_model.cmd_log.size(), n)
    for (int i = 0; i < n; i++)
      `CHK(u_ncap_nand_model.cmd_log[i], exp[8*(n-1-i) +: 8])
  endtask

  task automatic chk_addr(input logic [29:0] a, input int first,
                          input int base);
    for (int c = first; c < 5; c++)
      `CHK(u_ncap_nand_model.addr_log[base+c-first], ab(a, c))
  endtask

  // ---------------------------------------------------------------
  // scenarios
  // ---------------------------------------------------------------
  task automatic t_busy_and_supply();
    // a frozen block must not take even an always-legal request
    en <= 1'b0;
    try_refused(ncap_pkg::OP_STATUS);
    en <= 1'b1;
    hold_busy <= 1'b1;
    try_refused(ncap_pkg::OP_ERASE);
    run_op(ncap_pkg::OP_STATUS, 30'h0, 30'h0, 12'd1);
    hold_busy <= 1'b0;
    chk_cmds(32'h70, 1);
    `CHK(rx[0][7:0], 8'he0)
    supply_ok <= 1'b0;
    try_refused(ncap_pkg::OP_PAGE_READ);
    supply_ok <= 1'b1;
  endtask

  task automatic t_page_read();
    rd_ready <= 1'b0;
    fork
      run_op(ncap_pkg::OP_PAGE_READ, A1, 30'h0, 12'd4);
      begin
        repeat (400) @(posedge clk);
        `CHK(u_ncap_nand_model.n_re, 2)
        rd_ready <= 1'b1;
      end
    join
    chk_cmds(32'h0030, 2);
    `CHK(u_ncap_nand_model.addr_log.size(), 5)
    chk_addr(A1, 0, 0);
    for (int c = 0; c < 5; c++)
      `CHK(u_ncap_nand_model_w.addr_log[c], ab16(A1, c))
    `CHK(rx.size(), 4)
    for (int i = 0; i < 4; i++) `CHK(rx[i][7:0], 8'(i * 17))
  endtask

  task automatic t_program();
    wr_valid <= 1'b1;
    run_op(ncap_pkg::OP_PROGRAM, A2, 30'h0, 12'd2);
    wr_valid <= 1'b0;
    chk_cmds(32'h8010, 2);
    chk_addr(A2, 0, 0);
    `CHK(u_ncap_nand_model.data_log.size(), 2)
    `CHK(u_ncap_nand_model.data_log[0][7:0], 8'ha5)
    `CHK(u_ncap_nand_model.data_log[1][7:0], 8'ha6)
    `CHK(u_ncap_nand_model_w.data_log[0], 16'h00a5)
    `CHK(u_ncap_nand_model_w.data_log[1], 16'h00a6)
  endtask

  task automatic t_erase_copy();
    run_op(ncap_pkg::OP_ERASE, A1, 30'h0, 12'd0);
    chk_cmds(32'h60d0, 2);
    chk_addr(A1, 2, 0);
    run_op(ncap_pkg::OP_ERASE_DUAL, A1, A2, 12'd0);
    chk_cmds(32'h6060d0, 3);
    chk_addr(A2, 2, 3);
    run_op(ncap_pkg::OP_COPY_DUAL, A1, A2, 12'd0);
    chk_cmds(32'h85118110, 4);
    `CHK(u_ncap_nand_model.addr_log.size(), 10)
    chk_addr(A2, 0, 5);
  endtask

  task automatic t_singles();
    run_op(ncap_pkg::OP_EDC, 30'h0, 30'h0, 12'd1);
    chk_cmds(32'h7b, 1);
    `CHK(rx[0][7:0], 8'h5a)
    run_op(ncap_pkg::OP_IDENT, 30'h0, 30'h0, 12'd1);
    chk_cmds(32'h90, 1);
    `CHK(u_ncap_nand_model.addr_log[0], 16'h0000)
    `CHK(rx[0][7:0], 8'hc3)
    run_op(ncap_pkg::OP_RESET, 30'h0, 30'h0, 12'd0);
    chk_cmds(32'hff, 1);
  endtask

  initial begin
    repeat (2) @(posedge clk);
    rstn <= 1'b1;
    repeat (3) @(posedge clk);
    t_busy_and_supply();
    t_page_read();
    t_program();
    t_erase_copy();
    t_singles();
    `CHK(u_ncap_nand_model.n_viol, 0)
    `CHK(u_ncap_nand_model_w.n_viol, 0)
    report_and_stop();
  end
endmodule
